// ===== logic/sbi_pkg.sv
// Purpose: Shared constants and types for the SDRAM burst interrupt engine
// Assumes: One 250 MHz clock, pin-level commands from the controller side, decoded by the engine
// Notes: Functional notes below list the behaviour kept by the engine
// Functional notes
// [RULE1] Precharge to the written bank stops storing data that same cycle.
// [RULE2] Controller raises both byte masks with an interrupting precharge.
// [RULE3] Only a precharge to the burst's bank ends the write burst.
// [RULE4] Controller precharges one cycle after last beat to keep all data.
// [RULE5] Full-page read runs columns start..start+255, then wraps.
// [RULE6] Full-page write runs columns start..start+255, then wraps.
// [RULE7] Controller ends full-page bursts with burst stop, then precharges.
// [RULE8] After read burst stop, data drives for read latency cycles.
// [RULE9] After write burst stop, no further data is stored at once.
// [RULE10] Read mask: byte goes high-impedance two cycles after mask rises.
// [RULE11] Upper mask owns bits 15..8, lower mask owns bits 7..0.
// [RULE12] Read masking hits drivers only; column counter keeps advancing.
// [RULE13] Write mask blocks a byte in the same cycle it is high.
// [RULE14] Write masking blocks storing only; column counter keeps advancing.
// [RULE15] Burst-read-single-write: each write stores exactly one item.
// [RULE16] Controller activates a bank only after precharge time, when idle.
// [RULE17] Controller spaces activates to the two banks by the interval.
// [RULE18] Controller respects min and max activate-to-precharge times.
// [RULE19] Controller waits activate-to-column delay before read or write.
// [RULE20] Clock enable low during a burst freezes state at next edge.
// [RULE21] Clock enable high resumes at next edge; controller waits recovery.
// [RULE22] Controller ends suspend in time to meet the refresh period.
// [RULE23] Precharge with bit 10 low closes one bank, high closes both.
// [RULE24] Precharge during a read keeps output for read latency cycles.
// [RULE25] Each bank's state is tracked on its own.
package sbi_pkg;
    localparam int DATA_W = 16;
    localparam int COL_W = 8;
    localparam int ADDR_W = 12;
    localparam int ALL_BANKS_SELECT_BIT = 10;
    localparam int BANK_SELECT_BIT = 11;
    localparam int READ_MASK_DELAY = 2;
    localparam int WRITE_STOP_DELAY = 0;
    localparam int WRITE_RECOVERY_TIME = 1;
    localparam int LAT_MAX = 3;
    localparam logic [COL_W-1:0] COL_RESET = 8'h00;
    localparam logic [3:0] BL_RESET = 4'h0;

    // Command codes in the order cs, ras, cas, we (active low on the pins)
    typedef enum logic [3:0] {
        SBI_CMD_NOP = 4'h7,
        SBI_CMD_ACT = 4'h3,
        SBI_CMD_READ = 4'h5,
        SBI_CMD_WRITE = 4'h4,
        SBI_CMD_STOP = 4'h6,
        SBI_CMD_PRE = 4'h2
    } sbi_cmd_e;

    typedef enum logic [1:0] {
        SBI_IDLE = 2'h0,
        SBI_ACTIVE = 2'h1,
        SBI_BURST = 2'h3,
        SBI_PRECH = 2'h2
    } sbi_bank_e;

    typedef enum logic [1:0] {
        SBI_ENG_IDLE = 2'h0,
        SBI_ENG_READ = 2'h1,
        SBI_ENG_WRITE = 2'h3
    } sbi_eng_e;

    // One controller command beat
    typedef struct packed {
        logic [3:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic [1:0] mask;
    } sbi_req_s;

    // One store into the array
    typedef struct packed {
        logic bank;
        logic [COL_W-1:0] col;
        logic [1:0] bytes;
        logic [DATA_W-1:0] data;
    } sbi_store_s;
endpackage

// ===== logic/sbi_pipe.sv
// Purpose: Fixed-depth delay line for read data and byte-drive enables
// Assumes: Shifts only when enabled, so a suspend freezes it
// Notes: Tap chosen by latency, output comes from a register
`timescale 1ns/1ps
module sbi_pipe
    import sbi_pkg::*;
#(
    parameter int W = 18,
    parameter int DEPTH = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [1:0] tap,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage_reg [DEPTH];
    logic [W-1:0] stage_next [DEPTH];

    // Shift by one when enabled
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            stage_next[i] = stage_reg[i];
        end
        if (en) begin
            stage_next[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_next[i] = stage_reg[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end

    // Tap 1 is the first stage; out-of-range taps clamp to the last one
    always_comb begin
        if (tap == 2'h0 || int'(tap) > DEPTH) begin
            dout = stage_reg[DEPTH-1];
        end else begin
            dout = stage_reg[int'(tap)-1];
        end
    end
endmodule // sbi_pipe

// ===== logic/sbi_engine.sv
// Purpose: Burst engine with interruption, byte masking and clock suspend
// Assumes: Controller keeps its own timing; array lives outside this block
// Notes: Read path is a latency pipe so stop and precharge tails fall out
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sbi_engine
    import sbi_pkg::*;
#(
    parameter int FULL_PAGE_LEN = 256
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire sbi_req_s req,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [1:0] read_latency,
    input wire logic [3:0] burst_len,
    input wire logic single_write,
    output sbi_store_s store,
    output logic store_valid,
    output logic [COL_W-1:0] read_col,
    output logic read_bank,
    output logic read_fetch,
    input wire logic [DATA_W-1:0] read_data,
    output logic [DATA_W-1:0] dq_out,
    output logic [1:0] dq_oe_n,
    output logic [1:0] bank_state,
    output logic suspended
);
    sbi_eng_e eng_reg, eng_next;
    sbi_bank_e bank_reg [2];
    sbi_bank_e bank_next [2];
    logic [COL_W-1:0] col_reg, col_next;
    logic [8:0] left_reg, left_next;
    logic full_reg, full_next;
    logic bank_sel_reg, bank_sel_next;
    logic susp_reg, susp_next;
    sbi_store_s store_reg, store_next;
    logic store_v_reg, store_v_next;
    logic [1:0] mask_d1_reg, mask_d1_next;
    logic [1:0] mask_d2_reg, mask_d2_next;
    logic [DATA_W+1:0] pipe_out;
    logic run;
    logic cmd_ok;
    logic pre_hits;
    logic [1:0] pre_banks;
    logic rd_active;

    // Burst length code: 0..3 give 1,2,4,8; anything else is full page
    function automatic logic [8:0] burst_beats(input logic [3:0] code);
        logic [8:0] n;
        n = 9'h000;
        unique case (code)
            4'h0: n = 9'h001;
            4'h1: n = 9'h002;
            4'h2: n = 9'h004;
            4'h3: n = 9'h008;
            default: n = 9'(FULL_PAGE_LEN);
        endcase
        return n;
    endfunction

    // Banks closed by a precharge command
    function automatic logic [1:0] pre_target(input logic [ADDR_W-1:0] a);
        logic [1:0] t;
        t = 2'h0;
        if (a[ALL_BANKS_SELECT_BIT]) begin
            t = 2'h3; // RULE23
        end else begin
            t[a[BANK_SELECT_BIT]] = 1'b1; // RULE23
        end
        return t;
    endfunction

    // Suspend gates every edge-driven update except the store strobe, which clears; commands included
    assign run = !susp_reg; // RULE20
    // The edge that first sees the enable low still acts in full; the
    // freeze starts one edge later, so no beat is half taken
    assign cmd_ok = run; // RULE20
    assign pre_banks = pre_target(req.addr);
    assign pre_hits = (sbi_cmd_e'(req.cmd) == SBI_CMD_PRE)
        && pre_banks[bank_sel_reg]; // RULE3
    assign rd_active = (eng_reg == SBI_ENG_READ) && run;

    // Clock-suspend tracker: enter and leave one edge after the pin moves
    always_comb begin
        susp_next = !clock_enable; // RULE20 RULE21
    end

    // Burst engine and per-bank state
    always_comb begin
        eng_next = eng_reg;
        col_next = col_reg;
        left_next = left_reg;
        full_next = full_reg;
        bank_sel_next = bank_sel_reg;
        store_next = store_reg;
        store_v_next = 1'b0;
        for (int b = 0; b < 2; b++) begin
            bank_next[b] = bank_reg[b];
            if (bank_reg[b] == SBI_PRECH && run) begin
                bank_next[b] = SBI_IDLE;
            end
        end
        if (run && eng_reg != SBI_ENG_IDLE) begin
            // Counter walks on even through masked beats
            col_next = col_reg + 8'h01; // RULE5 RULE6 RULE12 RULE14
            if (!full_reg) begin
                left_next = left_reg - 9'h001;
                if (left_reg == 9'h001) begin
                    eng_next = SBI_ENG_IDLE;
                    bank_next[bank_sel_reg] = SBI_ACTIVE;
                end
            end
        end
        // Write beat stored unless cut by stop or by a precharge to the burst's bank this cycle
        if (cmd_ok && eng_reg == SBI_ENG_WRITE
                && sbi_cmd_e'(req.cmd) != SBI_CMD_STOP // RULE9
                && !pre_hits) begin // RULE1
            store_next.bank = bank_sel_reg;
            store_next.col = col_reg;
            store_next.bytes = ~req.mask; // RULE11 RULE13
            store_next.data = dq_in;
            store_v_next = |(~req.mask);
        end
        if (cmd_ok) begin
            unique case (sbi_cmd_e'(req.cmd))
                SBI_CMD_ACT: begin
                    bank_next[req.addr[BANK_SELECT_BIT]] = SBI_ACTIVE;
                end
                SBI_CMD_STOP: begin
                    eng_next = SBI_ENG_IDLE; // RULE8 RULE9
                    if (eng_reg != SBI_ENG_IDLE) begin
                        bank_next[bank_sel_reg] = SBI_ACTIVE;
                    end
                end
                SBI_CMD_PRE: begin
                    for (int b = 0; b < 2; b++) begin
                        if (pre_banks[b]) begin
                            bank_next[b] = SBI_PRECH; // RULE25
                        end
                    end
                    if (pre_hits) begin
                        eng_next = SBI_ENG_IDLE; // RULE1 RULE24
                    end
                end
                SBI_CMD_READ, SBI_CMD_WRITE: begin
                    bank_sel_next = req.addr[BANK_SELECT_BIT];
                    bank_next[req.addr[BANK_SELECT_BIT]] = SBI_BURST;
                    full_next = (burst_beats(burst_len)
                        == 9'(FULL_PAGE_LEN));
                    left_next = burst_beats(burst_len);
                    col_next = req.addr[COL_W-1:0];
                    eng_next = SBI_ENG_READ;
                    if (sbi_cmd_e'(req.cmd) == SBI_CMD_WRITE) begin
                        eng_next = SBI_ENG_WRITE;
                        // First beat lands with the command itself
                        store_next.bank = req.addr[BANK_SELECT_BIT];
                        store_next.col = req.addr[COL_W-1:0];
                        store_next.bytes = ~req.mask; // RULE13
                        store_next.data = dq_in;
                        store_v_next = |(~req.mask);
                        col_next = req.addr[COL_W-1:0] + 8'h01;
                        left_next = burst_beats(burst_len) - 9'h001;
                        if (single_write || left_next == 9'h000) begin
                            full_next = 1'b0; // RULE15
                            eng_next = SBI_ENG_IDLE;
                            bank_next[req.addr[BANK_SELECT_BIT]] =
                                SBI_ACTIVE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eng_reg <= SBI_ENG_IDLE;
            bank_reg[0] <= SBI_IDLE;
            bank_reg[1] <= SBI_IDLE;
            col_reg <= COL_RESET;
            left_reg <= 9'h000;
            full_reg <= 1'b0;
            bank_sel_reg <= 1'b0;
            susp_reg <= 1'b0;
            store_reg <= '0;
            store_v_reg <= 1'b0;
        end else begin
            eng_reg <= eng_next;
            bank_reg[0] <= bank_next[0];
            bank_reg[1] <= bank_next[1];
            col_reg <= col_next;
            left_reg <= left_next;
            full_reg <= full_next;
            bank_sel_reg <= bank_sel_next;
            susp_reg <= susp_next;
            store_reg <= store_next;
            store_v_reg <= store_v_next;
        end
    end

    // Read mask delay line: two edges from pin to driver
    always_comb begin
        mask_d1_next = mask_d1_reg;
        mask_d2_next = mask_d2_reg;
        if (run) begin
            mask_d1_next = req.mask; // RULE10
            mask_d2_next = mask_d1_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_d1_reg <= 2'h0;
            mask_d2_reg <= 2'h0;
        end else begin
            mask_d1_reg <= mask_d1_next;
            mask_d2_reg <= mask_d2_next;
        end
    end

    // Array fetch request for the current read column
    assign read_fetch = rd_active;
    assign read_col = col_reg;
    assign read_bank = bank_sel_reg;

    // Latency pipe carries data plus a drive flag per byte; the stop or
    // precharge tail is simply what is still inside it
    sbi_pipe #(
        .W(DATA_W + 2),
        .DEPTH(LAT_MAX)
    ) u_pipe (
        .clock(clock),
        .rst_n(rst_n),
        .en(run),
        .tap(read_latency - 2'h1),
        .din({rd_active, rd_active, read_data}),
        .dout(pipe_out)
    ); // RULE8 RULE24

    // Output stage: mask gates drivers only, never the burst
    always_comb begin
        dq_out = pipe_out[DATA_W-1:0];
        dq_oe_n[1] = !(pipe_out[DATA_W+1] && !mask_d2_reg[1]); // RULE10
        dq_oe_n[0] = !(pipe_out[DATA_W] && !mask_d2_reg[0]); // RULE11
    end

    assign store = store_reg;
    assign store_valid = store_v_reg;
    assign bank_state = {bank_reg[1] != SBI_IDLE, bank_reg[0] != SBI_IDLE};
    assign suspended = susp_reg;

    AST_PRE_CUTS_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_ok && eng_reg == SBI_ENG_WRITE && pre_hits |=> !store_v_reg)
        else $error("write stored after precharge"); // RULE1
    AST_OTHER_BANK_KEEPS: assert property (@(posedge clock)
        disable iff (!rst_n)
        cmd_ok && eng_reg == SBI_ENG_WRITE && !full_reg && left_reg > 9'h1
        && sbi_cmd_e'(req.cmd) == SBI_CMD_PRE && !pre_hits
        |=> eng_reg == SBI_ENG_WRITE)
        else $error("other-bank precharge ended burst"); // RULE3
    AST_STOP_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_ok && eng_reg == SBI_ENG_WRITE
        && sbi_cmd_e'(req.cmd) == SBI_CMD_STOP
        |=> !store_v_reg && eng_reg == SBI_ENG_IDLE)
        else $error("write stored on stop"); // RULE9
    AST_COL_ADV: assert property (@(posedge clock) disable iff (!rst_n)
        run && eng_reg != SBI_ENG_IDLE && clock_enable
        && sbi_cmd_e'(req.cmd) == SBI_CMD_NOP
        |=> col_reg == $past(col_reg) + 8'h01)
        else $error("column stalled"); // RULE5 RULE12 RULE14
    AST_MASK_TWO: assert property (@(posedge clock) disable iff (!rst_n)
        run && req.mask[0] ##1 run
        |=> dq_oe_n[0])
        else $error("lower byte driven two cycles after mask"); // RULE10
    AST_SUSP_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
        susp_reg |=> col_reg == $past(col_reg) && eng_reg == $past(eng_reg))
        else $error("state moved while suspended"); // RULE20
    AST_SUSP_EXIT: assert property (@(posedge clock) disable iff (!rst_n)
        susp_reg && clock_enable |=> !susp_reg)
        else $error("suspend not left"); // RULE21
    AST_PRE_ALL: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_ok && sbi_cmd_e'(req.cmd) == SBI_CMD_PRE
        && req.addr[ALL_BANKS_SELECT_BIT]
        |=> bank_reg[0] == SBI_PRECH && bank_reg[1] == SBI_PRECH)
        else $error("precharge-all missed a bank"); // RULE23 RULE25
    AST_SINGLE_WR: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_ok && single_write && sbi_cmd_e'(req.cmd) == SBI_CMD_WRITE
        |=> eng_reg == SBI_ENG_IDLE)
        else $error("single write kept bursting"); // RULE15

    COV_READ: cover property (@(posedge clock) disable iff (!rst_n)
        rd_active ##1 !dq_oe_n[0]);
    COV_WRITE_PRE: cover property (@(posedge clock) disable iff (!rst_n)
        eng_reg == SBI_ENG_WRITE && pre_hits && cmd_ok);
    COV_SUSPEND: cover property (@(posedge clock) disable iff (!rst_n)
        eng_reg != SBI_ENG_IDLE && susp_reg);
    COV_WRAP: cover property (@(posedge clock) disable iff (!rst_n)
        full_reg && col_reg == 8'hFF ##1 col_reg == 8'h00);
endmodule // sbi_engine

// ===== verification/sbi_array_model.sv
// Purpose: Behavioural memory array behind the burst engine
// Assumes: Fetches are answered in the same cycle; stores land on the edge
// Notes: Outside a fetch the data lines show the inverse of the last word
`timescale 1ns/1ps
module sbi_array_model
    import sbi_pkg::*;
(
    input wire logic clock,
    input wire sbi_store_s store,
    input wire logic store_valid,
    input wire logic [COL_W-1:0] read_col,
    input wire logic read_bank,
    input wire logic read_fetch,
    output logic [DATA_W-1:0] read_data
);
    logic [DATA_W-1:0] mem [0:511];
    logic [DATA_W-1:0] last_word;
    logic [8:0] wa;
    assign wa = {store.bank, store.col};
    // Pattern tied to bank and column keeps read expectations simple
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = {7'h2A, 9'(i)};
        end
        last_word = 16'h0000;
    end
    // Per-byte store, so a masked byte keeps its old contents
    always @(posedge clock) begin
        if (store_valid === 1'b1) begin
            if (store.bytes[1]) mem[wa][15:8] <= store.data[15:8];
            if (store.bytes[0]) mem[wa][7:0] <= store.data[7:0];
        end
        if (read_fetch === 1'b1) last_word <= read_data;
    end
    // Stale data is inverted so a missed fetch cannot look right by luck
    always_comb begin
        read_data = read_fetch ? mem[{read_bank, read_col}] : ~last_word;
    end
endmodule // sbi_array_model

// ===== verification/sbi_engine_tb_top.sv
// Purpose: Self-checking bench for the burst interrupt engine
// Assumes: Bench plays the memory controller, array model sits behind
// Notes: Outputs are checked 1 ns after each edge, once they settle
`timescale 1ns/1ps
module sbi_engine_tb_top;
    import sbi_pkg::*;
    logic clock, rst_n, clock_enable, ce_want, single_write, store_valid;
    logic read_bank, read_fetch, suspended;
    logic [1:0] read_latency, dq_oe_n, bank_state;
    logic [3:0] burst_len;
    logic [7:0] read_col;
    logic [15:0] dq_in, read_data, dq_out;
    sbi_req_s req;
    sbi_store_s store;
    sbi_store_s seen_q [$];
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    sbi_engine dut_u (.clock(clock), .rst_n(rst_n),
        .clock_enable(clock_enable), .req(req), .dq_in(dq_in),
        .read_latency(read_latency), .burst_len(burst_len),
        .single_write(single_write), .store(store),
        .store_valid(store_valid), .read_col(read_col),
        .read_bank(read_bank), .read_fetch(read_fetch),
        .read_data(read_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .bank_state(bank_state), .suspended(suspended));
    sbi_array_model mem_u (.clock(clock), .store(store),
        .store_valid(store_valid), .read_col(read_col),
        .read_bank(read_bank), .read_fetch(read_fetch),
        .read_data(read_data));

    task automatic conclude();
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    function automatic logic [11:0] ad(input logic b, input logic [7:0] c);
        return {b, 3'b000, c};
    endfunction

    // One command cycle; on return outputs reflect the edge just passed
    task automatic step(input sbi_cmd_e c, input logic [11:0] a,
                        input logic [1:0] m, input logic [15:0] d);
        @(posedge clock);
        req <= '{cmd: c, addr: a, mask: m};
        dq_in <= d;
        clock_enable <= ce_want;
        #1;
    endtask

    // Store seen now belongs to the beat of the previous step
    task automatic st(input logic v, input logic [8:0] bc,
                      input logic [1:0] by, input logic [15:0] d);
        logic [15:0] bm;
        bm = {{8{by[1]}}, {8{by[0]}}};
        chk(store_valid, v);
        if (v) begin
            chk({store.bank, store.col, store.bytes}, {bc, by});
            chk(store.data & bm, d & bm);
        end
    endtask

    // Read burst cut by command sc (stop or precharge) at step ts; masks pulse at steps 20..22 and 30
    task automatic rd(input logic b, input logic [7:0] c, input sbi_cmd_e sc,
                      input logic [11:0] sa, input int ts, input int nb);
        logic [1:0] mk [0:299];
        logic [1:0] eo;
        logic [15:0] ex;
        logic [15:0] bm;
        logic [7:0] cc;
        sbi_cmd_e k;
        int j;
        for (int t = 0; t < ts + 6; t++) begin
            mk[t] = {t >= 20 && t <= 22, t == 30};
            k = (t == 0) ? SBI_CMD_READ : (t == ts) ? sc : SBI_CMD_NOP;
            step(k, (t == 0) ? ad(b, c) : sa, mk[t], 16'h0000);
            j = t - int'(read_latency);
            eo = (j >= 0 && j < ts && j < nb) ? 2'b00 : 2'b11;
            if (t >= 2) eo = eo | mk[t - 2];
            cc = c + 8'(j);
            ex = b ? {8'hC3, cc - 8'hF0} : {7'h2A, 1'b0, cc};
            bm = {{8{~eo[1]}}, {8{~eo[0]}}};
            chk(dq_oe_n, eo);
            chk(dq_out & bm, ex & bm);
        end
    endtask

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Store monitor and hang guard
    always @(posedge clock) begin
        if (store_valid === 1'b1) seen_q.push_back(store);
        cycles++;
        if (cycles > 2000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        rst_n = 1'b0;
        ce_want = 1'b1;
        clock_enable = 1'b1;
        single_write = 1'b0;
        read_latency = 2'd2;
        burst_len = 4'h2;
        req = '{cmd: SBI_CMD_NOP, addr: 12'h000, mask: 2'b00};
        dq_in = 16'h0000;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk({dq_oe_n, store_valid, bank_state, suspended}, 6'h30);
        // Open both banks, spaced and settled before column commands
        step(SBI_CMD_ACT, ad(0, 8'h00), 2'b00, 16'h0000);
        step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        step(SBI_CMD_ACT, ad(1, 8'h00), 2'b00, 16'h0000);
        repeat (3) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        chk(bank_state, 2'b11);
        // Write burst: byte mask, other-bank precharge, own-bank precharge
        step(SBI_CMD_WRITE, ad(0, 8'h10), 2'b00, 16'hA001);
        step(SBI_CMD_NOP, 12'h000, 2'b10, 16'hA002);
        st(1'b1, 9'h010, 2'b11, 16'hA001);
        step(SBI_CMD_PRE, ad(1, 8'h00), 2'b00, 16'hA003);
        st(1'b1, 9'h011, 2'b01, 16'hA002);
        step(SBI_CMD_PRE, ad(0, 8'h00), 2'b11, 16'hA004);
        st(1'b1, 9'h012, 2'b11, 16'hA003);
        step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        st(1'b0, 9'h000, 2'b00, 16'h0000);
        repeat (4) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        chk(bank_state, 2'b00);
        // Full-page write on bank 1, wrapping past the start column
        burst_len = 4'h4;
        step(SBI_CMD_ACT, ad(0, 8'h00), 2'b00, 16'h0000);
        step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        step(SBI_CMD_ACT, ad(1, 8'h00), 2'b00, 16'h0000);
        repeat (3) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        step(SBI_CMD_WRITE, ad(1, 8'hF0), 2'b00, 16'hC300);
        for (int i = 1; i < 258; i++) begin
            step(SBI_CMD_NOP, 12'h000, 2'b00, {8'hC3, 8'(i)});
            st(1'b1, {1'b1, 8'hF0 + 8'(i - 1)}, 2'b11,
                {8'hC3, 8'(i - 1)});
        end
        step(SBI_CMD_STOP, ad(1, 8'h00), 2'b00, 16'hFFFF);
        st(1'b1, 9'h1F1, 2'b11, 16'hC301);
        step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        st(1'b0, 9'h000, 2'b00, 16'h0000);
        // Full-page read with masks and stop, then precharge-cut read
        rd(1'b1, 8'hF0, SBI_CMD_STOP, 12'h000, 270, 100000);
        read_latency = 2'd3;
        burst_len = 4'h3;
        rd(1'b0, 8'h40, SBI_CMD_PRE, ad(0, 8'h00), 3, 8);
        chk(bank_state, 2'b10);
        // Clock suspend in mid write; held beat must be stored once
        step(SBI_CMD_ACT, ad(0, 8'h00), 2'b00, 16'h0000);
        repeat (3) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        seen_q.delete();
        step(SBI_CMD_WRITE, ad(0, 8'h60), 2'b00, 16'h7000);
        for (int i = 1; i < 8; i++) begin
            if (i == 3) ce_want = 1'b0;
            step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h7000 + 16'(i));
            if (i == 3) begin
                repeat (2) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h7003);
                chk(suspended, 1'b1);
                ce_want = 1'b1;
                step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h7003);
            end
            if (i == 5) chk(suspended, 1'b0);
        end
        repeat (3) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'hEEEE);
        chk(seen_q.size(), 8);
        foreach (seen_q[i]) chk({seen_q[i].col, seen_q[i].data},
            {8'h60 + 8'(i), 16'h7000 + 16'(i)});
        // Single-write option stores one item per write command
        single_write = 1'b1;
        seen_q.delete();
        step(SBI_CMD_WRITE, ad(0, 8'h70), 2'b00, 16'h1234);
        repeat (5) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h5555);
        chk(seen_q.size(), 1);
        single_write = 1'b0;
        // Precharge of all banks ignores the bank-select bit
        step(SBI_CMD_PRE, 12'h400, 2'b00, 16'h0000);
        repeat (3) step(SBI_CMD_NOP, 12'h000, 2'b00, 16'h0000);
        chk(bank_state, 2'b00);
        conclude();
    end
endmodule // sbi_engine_tb_top
